// *** logic/meh_regs.svh ***
`ifndef MEH_REGS_SVH
`define MEH_REGS_SVH
// ==========================================================================
// Processor address map.
`define MEH_DATA_PAGE 6'h04
`define MEH_PROG_PAGE 6'h02
`define MEH_LANE_MSB 2'h0
`define MEH_LANE_B2 2'h1
`define MEH_LANE_B1 2'h2
`define MEH_LANE_LSB 2'h3
// ==========================================================================
// Engine word addresses.
`define MEH_W_IA 8'h00
`define MEH_W_VA 8'h01
`define MEH_W_IB 8'h02
`define MEH_W_TEMP 8'h06
`define MEH_W_DIP_THR 8'h31
`define MEH_W_DIP_CNT 8'h32
`define MEH_W_NACC 8'h36
`define MEH_W_E0SUM 8'h43
`define MEH_W_E1SUM 8'h44
`define MEH_W_SQ0SUM 8'h4A
`define MEH_W_SQ1SUM 8'h4B
`define MEH_W_STATUS 8'h51
// ==========================================================================
// Status word fields.
`define MEH_ST_F0 28
`define MEH_ST_SAG 25
// ==========================================================================
// Timing.
`define MEH_CONV_CYCLES 3
`define MEH_CONV_PER_MUX 4
`define MEH_SETTLE_CYCLES 1
`define MEH_MUX_LEN_DIV2 4'hA
`define MEH_MUX_DIV_TWO 2'h2
`define MEH_CLK_NS 8
`define MEH_STATUS_VALID_NS 100000
`endif

// *** logic/meh_pkg.sv ***
package meh_pkg;
   typedef logic [7:0] meh_byte_t;
   typedef logic [31:0] meh_word_t;
   typedef logic [1:0] meh_div_t;
   typedef enum logic {MEH_EQU_TWO_WIRE, MEH_EQU_THREE_WIRE} meh_equ_e;
endpackage : meh_pkg

// *** logic/meh_timing_if.sv ***
`timescale 1ns/100ps
interface meh_timing_if;
   logic run;
   meh_pkg::meh_div_t divider;
   logic sample;
   logic pass;
   modport timer (input run, input divider, output sample, output pass);
   modport engine (output run, output divider, input sample, input pass);
endinterface : meh_timing_if

// *** logic/meh_pass_timer.sv ***
`timescale 1ns/100ps
`include "meh_regs.svh"
module meh_pass_timer (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_slow_crystal_clock,
   meh_timing_if.timer tif
);
   import meh_pkg::*;
   // ======================================================================
   // Slow clock edge detection.
   logic s1, s2, s3, level;
   logic [3:0] mux_cnt;
   logic sample, pass;
   wire agree = (s2 == s3);
   wire slow_edge = agree && s2 && !level;
   wire [3:0] mux_len = (tif.divider == `MEH_MUX_DIV_TWO) ?
      `MEH_MUX_LEN_DIV2 :
      4'(`MEH_CONV_CYCLES * `MEH_CONV_PER_MUX + `MEH_SETTLE_CYCLES);
   wire mux_end = slow_edge && (mux_cnt == mux_len - 4'h1);
   always_ff @(posedge i_clk) begin
      s1 <= i_slow_crystal_clock;
      s2 <= s1;
      s3 <= s2;
      if (!i_rst_n) begin
         level <= 1'b0;
      end else if (agree) begin
         level <= s2;
      end
   end
   // ======================================================================
   // Mux cycle counter; one sample and one pass per mux cycle.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !tif.run) begin
         mux_cnt <= 4'h0;
         sample <= 1'b0;
         pass <= 1'b0;
      end else begin
         if (mux_end) begin
            mux_cnt <= 4'h0;
         end else if (slow_edge) begin
            mux_cnt <= mux_cnt + 4'h1;
         end
         sample <= mux_end;
         pass <= sample;
      end
   end
   assign tif.sample = sample;
   assign tif.pass = pass;
   property p_mux_bound;
      @(posedge i_clk) disable iff (!i_rst_n) mux_cnt < mux_len;
   endproperty
   a_mux_bound: assert property (p_mux_bound)
      else $error("mux cycle counter passed its length");
endmodule : meh_pass_timer

// *** logic/meh_engine_port.sv ***
`timescale 1ns/100ps
`include "meh_regs.svh"
module meh_engine_port #(
   parameter int STATUS_HOLD_CYCLES = `MEH_STATUS_VALID_NS / `MEH_CLK_NS
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_slow_crystal_clock,
   input wire logic [15:0] i_addr,
   input wire meh_pkg::meh_byte_t i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output meh_pkg::meh_byte_t o_rdata,
   input wire logic i_run_enable,
   input wire meh_pkg::meh_equ_e i_meter_equation_select,
   input wire logic [7:0] i_presum_sample_count,
   input wire logic [5:0] i_sum_cycle_count,
   input wire meh_pkg::meh_div_t i_mux_cycle_divider,
   input wire meh_pkg::meh_word_t i_phase_a_current_raw,
   input wire meh_pkg::meh_word_t i_phase_a_voltage_raw,
   input wire meh_pkg::meh_word_t i_phase_b_current_raw,
   input wire meh_pkg::meh_word_t i_thermal_raw,
   output logic o_pass_interrupt,
   output logic o_transfer_ready_interrupt
);
   import meh_pkg::*;
   // ======================================================================
   // Pass timing.
   meh_timing_if tif ();
   assign tif.run = i_run_enable;
   assign tif.divider = i_mux_cycle_divider;
   meh_pass_timer u_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_slow_crystal_clock(i_slow_crystal_clock),
      .tif(tif)
   );
   // ======================================================================
   // Memories and engine state.
   meh_word_t data_mem [0:255];
   meh_word_t prog_mem [0:255];
   meh_word_t raw_phase_a_current, raw_phase_a_voltage;
   meh_word_t raw_phase_b_current, raw_thermal_sample;
   meh_word_t engine_status_word;
   meh_word_t e0_acc, e1_acc, sq0_acc, sq1_acc;
   meh_word_t e0_sum, e1_sum, sq0_sum, sq1_sum;
   logic [13:0] acc_cnt;
   logic acc_hit;
   meh_word_t dip_run;
   logic f0;
   logic va_neg;
   // ======================================================================
   // Address decode.
   wire in_data = (i_addr[15:10] == `MEH_DATA_PAGE);
   wire in_prog = (i_addr[15:10] == `MEH_PROG_PAGE);
   wire [7:0] widx = i_addr[9:2];
   wire [1:0] lane = i_addr[1:0];
   wire [13:0] nacc = i_presum_sample_count * i_sum_cycle_count;
   wire meh_word_t dip_thr = data_mem[`MEH_W_DIP_THR];
   wire meh_word_t dip_cnt = data_mem[`MEH_W_DIP_CNT];
   wire meh_word_t data_word =
      (widx == `MEH_W_IA) ? raw_phase_a_current :
      (widx == `MEH_W_VA) ? raw_phase_a_voltage :
      (widx == `MEH_W_IB) ? raw_phase_b_current :
      (widx == `MEH_W_TEMP) ? raw_thermal_sample :
      (widx == `MEH_W_NACC) ? {18'h0, nacc} :
      (widx == `MEH_W_E0SUM) ? e0_sum :
      (widx == `MEH_W_E1SUM) ? e1_sum :
      (widx == `MEH_W_SQ0SUM) ? sq0_sum :
      (widx == `MEH_W_SQ1SUM) ? sq1_sum :
      (widx == `MEH_W_STATUS) ? engine_status_word :
      (widx < 8'h08) ? 32'h0 : data_mem[widx];
   wire meh_word_t sel_word = in_data ? data_word :
      in_prog ? prog_mem[widx] : 32'h0;
   wire meh_byte_t sel_byte =
      (lane == `MEH_LANE_MSB) ? sel_word[31:24] :
      (lane == `MEH_LANE_B2) ? sel_word[23:16] :
      (lane == `MEH_LANE_B1) ? sel_word[15:8] : sel_word[7:0];
   // A byte write replaces one lane and keeps the other three.
   wire meh_word_t wr_mask = 32'hFF000000 >> {lane, 3'h0};
   wire meh_word_t wr_bits = {4{i_wdata}} & wr_mask;
   // ======================================================================
   // Element inputs, upper halves only to bound multiplier width.
   wire signed [15:0] ia_h = i_phase_a_current_raw[31:16];
   wire signed [15:0] va_h = i_phase_a_voltage_raw[31:16];
   wire signed [15:0] ib_h = i_phase_b_current_raw[31:16];
   wire signed [16:0] diff = ia_h - ib_h;
   wire signed [15:0] half = 16'(diff >>> 1);
   wire signed [15:0] diff_s = 16'(diff);
   wire equ1 = (i_meter_equation_select == MEH_EQU_THREE_WIRE);
   wire signed [31:0] e0 = equ1 ? va_h * half : va_h * ia_h;
   wire signed [31:0] e1 = va_h * ib_h;
   wire signed [31:0] sq0 = equ1 ? diff_s * diff_s : ia_h * ia_h;
   wire signed [31:0] sq1 = ib_h * ib_h;
   wire va_below = $signed(i_phase_a_voltage_raw) < $signed(dip_thr);
   wire meh_word_t next_dip_run = va_below ?
      ((dip_run == 32'hFFFFFFFF) ? dip_run : dip_run + 32'h1) : 32'h0;
   wire sag_now = (dip_cnt != 32'h0) && (dip_run >= dip_cnt);
   wire meh_word_t next_status =
      (32'h1 << `MEH_ST_F0) * 32'(f0) |
      (32'h1 << `MEH_ST_SAG) * 32'(sag_now);
   // ======================================================================
   // Processor access. Reads return one cycle after i_rd.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= sel_byte;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_wr && in_data) begin
         data_mem[widx] <= (data_mem[widx] & ~wr_mask) | wr_bits;
      end
      if (i_wr && in_prog) begin
         prog_mem[widx] <= (prog_mem[widx] & ~wr_mask) | wr_bits;
      end
   end
   // ======================================================================
   // Sample capture and accumulation.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         raw_phase_a_current <= 32'h0;
         raw_phase_a_voltage <= 32'h0;
         raw_phase_b_current <= 32'h0;
         raw_thermal_sample <= 32'h0;
         e0_acc <= 32'h0;
         e1_acc <= 32'h0;
         sq0_acc <= 32'h0;
         sq1_acc <= 32'h0;
         acc_cnt <= 14'h0;
         acc_hit <= 1'b0;
         dip_run <= 32'h0;
         f0 <= 1'b0;
         va_neg <= 1'b0;
      end else if (tif.sample) begin
         raw_phase_a_current <= i_phase_a_current_raw;
         raw_phase_a_voltage <= i_phase_a_voltage_raw;
         raw_phase_b_current <= i_phase_b_current_raw;
         raw_thermal_sample <= i_thermal_raw;
         e0_acc <= e0_acc + e0;
         e1_acc <= e1_acc + e1;
         sq0_acc <= sq0_acc + sq0;
         sq1_acc <= sq1_acc + sq1;
         acc_cnt <= acc_cnt + 14'h1;
         acc_hit <= (acc_cnt + 14'h1 >= nacc);
         dip_run <= next_dip_run;
         va_neg <= i_phase_a_voltage_raw[31];
         // A rising zero crossing starts the high half, a falling one ends it.
         if (va_neg && !i_phase_a_voltage_raw[31]) begin
            f0 <= 1'b1;
         end else if (!va_neg && i_phase_a_voltage_raw[31]) begin
            f0 <= 1'b0;
         end
      end else if (tif.pass && acc_hit) begin
         e0_acc <= 32'h0;
         e1_acc <= 32'h0;
         sq0_acc <= 32'h0;
         sq1_acc <= 32'h0;
         acc_cnt <= 14'h0;
         acc_hit <= 1'b0;
      end
   end
   // ======================================================================
   // Pass and transfer interrupts, status refresh and result publication.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_pass_interrupt <= 1'b0;
         o_transfer_ready_interrupt <= 1'b0;
         engine_status_word <= 32'h0;
         e0_sum <= 32'h0;
         e1_sum <= 32'h0;
         sq0_sum <= 32'h0;
         sq1_sum <= 32'h0;
      end else begin
         o_pass_interrupt <= tif.pass;
         o_transfer_ready_interrupt <= tif.pass && acc_hit;
         if (tif.pass) begin
            engine_status_word <= next_status;
         end
         if (tif.pass && acc_hit) begin
            e0_sum <= e0_acc;
            e1_sum <= e1_acc;
            sq0_sum <= sq0_acc;
            sq1_sum <= sq1_acc;
         end
      end
   end
   // ======================================================================
   // Checks. The hold counter exists only for the status validity check.
   int hold_cnt;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || o_pass_interrupt) begin
         hold_cnt <= 0;
      end else if (hold_cnt < STATUS_HOLD_CYCLES) begin
         hold_cnt <= hold_cnt + 1;
      end
   end
   property p_xfer_with_pass;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_transfer_ready_interrupt |-> o_pass_interrupt;
   endproperty
   a_xfer_with_pass: assert property (p_xfer_with_pass)
      else $error("transfer interrupt without pass interrupt");
   property p_pass_after_sample;
      @(posedge i_clk) disable iff (!i_rst_n || !i_run_enable)
      tif.sample |-> ##2 o_pass_interrupt;
   endproperty
   a_pass_after_sample: assert property (p_pass_after_sample)
      else $error("pass interrupt did not follow the sample");
   property p_status_zero_bits;
      @(posedge i_clk) disable iff (!i_rst_n)
      engine_status_word[31:29] == 3'h0 && engine_status_word[24:0] == 25'h0;
   endproperty
   a_status_zero_bits: assert property (p_status_zero_bits)
      else $error("unused status bits not zero");
   property p_status_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      (hold_cnt < STATUS_HOLD_CYCLES && !tif.pass) |=>
         $stable(engine_status_word);
   endproperty
   a_status_hold: assert property (p_status_hold)
      else $error("status word changed inside its valid window");
   property p_status_prev_pass;
      @(posedge i_clk) disable iff (!i_rst_n)
      tif.pass |=> engine_status_word[`MEH_ST_SAG] == $past(sag_now) &&
         engine_status_word[`MEH_ST_F0] == $past(f0);
   endproperty
   a_status_prev_pass: assert property (p_status_prev_pass)
      else $error("status word does not hold the preceding pass flags");
   property p_sag_release;
      @(posedge i_clk) disable iff (!i_rst_n)
      (tif.sample && !va_below) ##1 tif.pass |=>
         !engine_status_word[`MEH_ST_SAG];
   endproperty
   a_sag_release: assert property (p_sag_release)
      else $error("sag flag held after voltage rose above threshold");
   property p_read_msb_first;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == 16'h1004 && !tif.sample) |=>
         o_rdata == $past(raw_phase_a_voltage[31:24]);
   endproperty
   a_read_msb_first: assert property (p_read_msb_first)
      else $error("byte 0x1004 is not the voltage word's top byte");
   property p_read_nacc_lsb;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == 16'h10DB) |=> o_rdata == $past(nacc[7:0]);
   endproperty
   a_read_nacc_lsb: assert property (p_read_nacc_lsb)
      else $error("accumulation count byte read wrong");
   property p_f0_on_crossing;
      @(posedge i_clk) disable iff (!i_rst_n)
      (tif.sample && va_neg && !i_phase_a_voltage_raw[31]) |=> f0;
   endproperty
   a_f0_on_crossing: assert property (p_f0_on_crossing)
      else $error("square wave missed a rising crossing");
   property p_xfer_count;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_transfer_ready_interrupt |-> acc_cnt == 14'h0 && !acc_hit;
   endproperty
   a_xfer_count: assert property (p_xfer_count)
      else $error("accumulation not restarted at transfer");
   property p_pass_pulse;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_pass_interrupt |=> !o_pass_interrupt;
   endproperty
   a_pass_pulse: assert property (p_pass_pulse)
      else $error("pass interrupt lasted more than one cycle");
   property p_raw_capture;
      @(posedge i_clk) disable iff (!i_rst_n)
      tif.sample |=> raw_phase_b_current == $past(i_phase_b_current_raw) &&
         raw_thermal_sample == $past(i_thermal_raw);
   endproperty
   a_raw_capture: assert property (p_raw_capture)
      else $error("raw samples not captured on the sample pulse");
   property p_publish;
      @(posedge i_clk) disable iff (!i_rst_n)
      (tif.pass && acc_hit) |=> e1_sum == $past(e1_acc) &&
         sq1_sum == $past(sq1_acc);
   endproperty
   a_publish: assert property (p_publish)
      else $error("results not published at the transfer");
endmodule : meh_engine_port

// *** tb/meh_cpu_model.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Processor model: byte-wide reads and writes of engine words.
module meh_cpu_model (
   input wire logic i_clk,
   input wire meh_pkg::meh_byte_t i_rdata,
   output logic [15:0] o_addr,
   output meh_pkg::meh_byte_t o_wdata,
   output logic o_wr,
   output logic o_rd
);
   import meh_pkg::*;
   initial begin
      o_addr = 16'h0000;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // ==========================================================================
   // Word transfers, most significant byte first.
   task automatic wr_word(input logic [15:0] base, input meh_word_t w);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = base;
      o_wdata = w[31:24];
      for (int b = 1; b < 4; b++) begin
         @(negedge i_clk);
         o_addr = base + 16'(b);
         o_wdata = w[31-8*b -: 8];
      end
      @(negedge i_clk);
      o_wr = 1'b0;
      // Released lines show the inverse so stale values cannot pass.
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
   endtask : wr_word
   // Back-to-back byte reads keep the status read well inside its window.
   task automatic rd_word(input logic [15:0] base, output meh_word_t w);
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = base;
      for (int b = 0; b < 4; b++) begin
         @(negedge i_clk);
         w = {w[23:0], i_rdata};
         if (b < 3) begin
            o_addr = base + 16'(b + 1);
         end else begin
            o_rd = 1'b0;
            o_addr = ~o_addr;
         end
      end
   endtask : rd_word
   // ==========================================================================
   // Chopper polarity is a processor duty; the engine has no pin for it.
   logic [1:0] chopper_polarity_select = 2'h1;
   logic skip_toggle = 1'b0;
   task automatic on_pass(input logic xfer);
      if (!skip_toggle) begin
         chopper_polarity_select = ~chopper_polarity_select;
      end
      skip_toggle = xfer;
   endtask : on_pass
endmodule : meh_cpu_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import meh_pkg::*;
   localparam int HOLD = 20;
   // The crystal is scaled to 16 clock cycles so the run stays short.
   localparam int SLOW_CYC = 16;
   localparam int CEIL = 12000;
   typedef struct packed {
      logic ph;
      logic wr;
      logic [15:0] a;
      logic [31:0] v;
   } meh_row_s;
   localparam meh_row_s ROWS [0:13] = '{
      '{1'b0, 1'b1, 16'h10C4, 32'h0000_1000},
      '{1'b0, 1'b1, 16'h10C8, 32'h0000_0002},
      '{1'b0, 1'b0, 16'h10C4, 32'h0000_1000},
      '{1'b0, 1'b0, 16'h10C8, 32'h0000_0002},
      '{1'b0, 1'b0, 16'h10D8, 32'h0000_0006},
      '{1'b0, 1'b0, 16'h1144, 32'h0000_0000},
      '{1'b0, 1'b0, 16'h2000, 32'h0000_0000},
      '{1'b0, 1'b0, 16'h100C, 32'h0000_0000},
      '{1'b1, 1'b1, 16'h1000, 32'hFFFF_FFFF},
      '{1'b1, 1'b0, 16'h1000, 32'h1234_5678},
      '{1'b1, 1'b0, 16'h1004, 32'h8765_4321},
      '{1'b1, 1'b0, 16'h1008, 32'h0BAD_C0DE},
      '{1'b1, 1'b0, 16'h1018, 32'h2468_ACE1},
      '{1'b1, 1'b0, 16'h101C, 32'h0000_0000}
   };
   logic i_clk;
   logic i_rst_n;
   logic i_slow_crystal_clock;
   logic [15:0] i_addr;
   meh_byte_t i_wdata;
   logic i_wr;
   logic i_rd;
   meh_byte_t o_rdata;
   logic i_run_enable;
   meh_equ_e i_equ;
   logic [7:0] i_presum;
   logic [5:0] i_sum;
   meh_div_t i_div;
   meh_word_t i_ia;
   meh_word_t i_va;
   meh_word_t i_ib;
   meh_word_t i_temp;
   logic o_pass_interrupt;
   logic o_transfer_ready_interrupt;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int c;
   int n;
   meh_word_t w;
   meh_engine_port #(.STATUS_HOLD_CYCLES(HOLD)) DUT (
      .i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_slow_crystal_clock(i_slow_crystal_clock),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_run_enable(i_run_enable),
      .i_meter_equation_select(i_equ), .i_presum_sample_count(i_presum),
      .i_sum_cycle_count(i_sum), .i_mux_cycle_divider(i_div),
      .i_phase_a_current_raw(i_ia), .i_phase_a_voltage_raw(i_va),
      .i_phase_b_current_raw(i_ib), .i_thermal_raw(i_temp),
      .o_pass_interrupt(o_pass_interrupt),
      .o_transfer_ready_interrupt(o_transfer_ready_interrupt));
   meh_cpu_model cpu (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
   // ==========================================================================
   // Clocks, timeout and the transfer monitor.
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   initial begin
      i_slow_crystal_clock = 1'b0;
      #3;
      forever #(SLOW_CYC * 4) i_slow_crystal_clock = ~i_slow_crystal_clock;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == CEIL) begin
         errors++;
         end_sim();
      end
   end
   always @(negedge i_clk) begin
      if (i_rst_n === 1'b1 && o_transfer_ready_interrupt === 1'b1) begin
         chk("pass with transfer", o_pass_interrupt, 1);
      end
   end
   // ==========================================================================
   // Shared tasks.
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] ex);
      n_checks++;
      if (seen !== ex) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk
   task wait_pass(output int cyc);
      cyc = 0;
      do begin
         @(negedge i_clk);
         cyc++;
      end while (o_pass_interrupt !== 1'b1 && cyc < 600);
      if (o_pass_interrupt === 1'b1) begin
         cpu.on_pass(o_transfer_ready_interrupt === 1'b1);
      end
   endtask : wait_pass
   task run_rows(input logic ph);
      meh_word_t rv;
      for (int i = 0; i < 14; i++) begin
         if (ROWS[i].ph == ph && ROWS[i].wr) begin
            cpu.wr_word(ROWS[i].a, ROWS[i].v);
         end else if (ROWS[i].ph == ph) begin
            cpu.rd_word(ROWS[i].a, rv);
            chk($sformatf("row %0d", i), rv, ROWS[i].v);
         end
      end
      $display("test rows %0d done", ph);
   endtask : run_rows
   task st_step(input meh_word_t va, input logic f0, input logic sag);
      wait_pass(c);
      cpu.rd_word(16'h1144, w);
      chk("status unused", {w[31:29], w[24:0]}, 0);
      chk("status f0", w[28], f0);
      chk("status sag", w[25], sag);
      i_va = va;
   endtask : st_step
   task end_sim();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   // ==========================================================================
   // Main sequence.
   initial begin
      i_rst_n = 1'b0;
      i_run_enable = 1'b0;
      i_equ = MEH_EQU_TWO_WIRE;
      i_presum = 8'h02;
      i_sum = 6'h03;
      i_div = 2'h1;
      i_ia = 32'h1234_5678;
      i_va = 32'h8765_4321;
      i_ib = 32'h0BAD_C0DE;
      i_temp = 32'h2468_ACE1;
      repeat (2) @(negedge i_clk);
      chk("reset rdata", o_rdata, 0);
      chk("reset irq", {o_pass_interrupt, o_transfer_ready_interrupt}, 0);
      i_rst_n = 1'b1;
      $display("test reset done");
      run_rows(1'b0);
      i_run_enable = 1'b1;
      wait_pass(c);
      wait_pass(c);
      chk("pass gap div1", c, 13 * SLOW_CYC);
      n = 0;
      do begin
         wait_pass(c);
         n++;
      end while (o_transfer_ready_interrupt !== 1'b1 && n < 20);
      n = 0;
      do begin
         wait_pass(c);
         n++;
      end while (o_transfer_ready_interrupt !== 1'b1 && n < 20);
      chk("transfer gap", n, 6);
      cpu.rd_word(16'h1128, w);
      chk("eq0 square sum", w, 32'h07C4_1F60);
      cpu.rd_word(16'h1110, w);
      chk("eq0 element1", w, 32'hDEFF_0586);
      $display("test timing done");
      run_rows(1'b1);
      st_step(32'h0100_0000, 1'b0, 1'b1);
      st_step(32'h8765_4321, 1'b1, 1'b0);
      st_step(32'h8765_4321, 1'b0, 1'b0);
      st_step(32'h8765_4321, 1'b0, 1'b1);
      chk("chopper legal", ^cpu.chopper_polarity_select, 1);
      $display("test status done");
      i_run_enable = 1'b0;
      i_div = 2'h2;
      i_equ = MEH_EQU_THREE_WIRE;
      i_presum = 8'h01;
      i_sum = 6'h01;
      i_ia = 32'h0100_0000;
      i_ib = 32'h0100_0000;
      @(negedge i_clk);
      i_run_enable = 1'b1;
      wait_pass(c);
      wait_pass(c);
      chk("pass gap div2", c, 10 * SLOW_CYC);
      wait_pass(c);
      cpu.rd_word(16'h110C, w);
      chk("eq1 element0", w, 0);
      cpu.rd_word(16'h1128, w);
      chk("eq1 square0", w, 0);
      cpu.rd_word(16'h112C, w);
      chk("eq1 square1", w, 32'h0001_0000);
      $display("test equation done");
      cpu.rd_word(16'h1018, w);
      chk("temp before reset", w, 32'h2468_ACE1);
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clk);
      chk("mid reset rdata", o_rdata, 0);
      chk("mid reset irq", {o_pass_interrupt, o_transfer_ready_interrupt}, 0);
      i_rst_n = 1'b1;
      cpu.rd_word(16'h1144, w);
      chk("mid reset status", w, 0);
      $display("test mid reset done");
      end_sim();
   end
endmodule : testbench
